//--- dsv_demo_start.v
// Demo start-up sequencer, servo steering and APB register file
`timescale 1ns/1ps
`include "dsv_regs.vh"
module dsv_demo_start #(
	parameter [31:0] SETTLE_CYC = `DSV_SETTLE_MS * `DSV_CLK_KHZ,
	parameter [31:0] FRAME_CYC  = `DSV_SERVO_FRAME_MS * `DSV_CLK_KHZ,
	parameter [31:0] MIN_CYC    = `DSV_SERVO_MIN_MS * `DSV_CLK_KHZ,
	parameter [31:0] MAX_CYC    = `DSV_SERVO_MAX_MS * `DSV_CLK_KHZ
) (
	input  wire        mclk_in,
	input  wire        rst_in,
	input  wire        demo_jumper_in,
	input  wire        slave_jumper_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output wire        pready_out,
	output wire        pslverr_out,
	output reg         sensor_reset_cmd_out,
	output reg         sensor_register_write_cmd_out,
	output reg  [7:0]  sreg_addr_out,
	output reg  [7:0]  sreg_data_out,
	input  wire        sreg_done_in,
	output reg         track_window_cmd_out,
	input  wire        centroid_valid_in,
	input  wire [7:0]  centroid_x_in,
	output wire        host_serial_en_out,
	input  wire        pix_valid_in,
	input  wire [7:0]  red_in,
	input  wire [7:0]  green_in,
	input  wire [7:0]  blue_in,
	output wire        pix_valid_out,
	output wire [7:0]  red_out,
	output wire [7:0]  green_out,
	output wire [7:0]  blue_out,
	output wire        servo_out
);
	localparam [8:0] ST_STRAP  = 9'h001;
	localparam [8:0] ST_CRST   = 9'h002;
	localparam [8:0] ST_SETTLE = 9'h004;
	localparam [8:0] ST_WR18   = 9'h008;
	localparam [8:0] ST_WR19   = 9'h010;
	localparam [8:0] ST_TRACK  = 9'h020;
	localparam [8:0] ST_RUN    = 9'h040;
	localparam [8:0] ST_SLAVE  = 9'h080;
	localparam [8:0] ST_HOST   = 9'h100;
	localparam [31:0] STEP_CYC = (MAX_CYC - MIN_CYC) >> 8;

	reg  [8:0]  state_q;
	reg  [8:0]  state_d;
	reg  [31:0] cnt_q;
	reg  [31:0] cnt_d;
	reg         demo_q;
	reg         slave_q;
	reg         invert_q;
	reg         servo_en_q;
	reg  [7:0]  pos_q;
	reg  [7:0]  cx_q;
	reg  [1:0]  mass_mode_q;
	reg         host_ycc_q;
	reg         demo_ycc_q;
	reg         host_track_q;
	wire        apb_access;
	wire        apb_wr;
	wire        addr_ok;
	wire        wr_refused;
	wire        ctrl_wr;
	wire        cx_right;
	wire        cx_left;

	function [7:0] step_pos;
		input [7:0] p;
		input       up;
		begin
			if (up)
				step_pos = (p == 8'hFF) ? p : p + 8'h01;
			else
				step_pos = (p == 8'h00) ? p : p - 8'h01;
		end
	endfunction

	// Zero-wait APB slave
	assign apb_access  = psel_in && penable_in;
	assign apb_wr      = apb_access && pwrite_in;
	assign addr_ok     = (paddr_in == `DSV_ADDR_CTRL) || (paddr_in == `DSV_ADDR_STATUS) ||
	                     (paddr_in == `DSV_ADDR_SERVO) || (paddr_in == `DSV_ADDR_CENTROID);
	assign wr_refused  = apb_wr && demo_q;
	assign ctrl_wr     = apb_wr && !demo_q && (paddr_in == `DSV_ADDR_CTRL);
	assign pready_out  = 1'b1;
	assign pslverr_out = apb_access && (!addr_ok || wr_refused);
	assign host_serial_en_out = !demo_q;

	// Sequencer
	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_STRAP: begin
				cnt_d = 32'h00000000;
				if (demo_jumper_in)
					state_d = ST_CRST;
				else if (slave_jumper_in)
					state_d = ST_SLAVE;
				else
					state_d = ST_HOST;
			end
			ST_CRST: begin
				cnt_d = cnt_q + 32'h00000001;
				if (cnt_q >= {16'h0000, `DSV_CAM_RST_CYC} - 32'h00000001) begin
					cnt_d   = 32'h00000000;
					state_d = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				cnt_d = cnt_q + 32'h00000001;
				if (cnt_q >= SETTLE_CYC - 32'h00000001) begin
					cnt_d   = 32'h00000000;
					state_d = ST_WR18;
				end
			end
			ST_WR18: begin
				if (sreg_done_in)
					state_d = ST_WR19;
			end
			ST_WR19: begin
				if (sreg_done_in)
					state_d = ST_TRACK;
			end
			ST_TRACK: begin
				state_d = ST_RUN;
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			ST_SLAVE: begin
				state_d = ST_SLAVE;
			end
			ST_HOST: begin
				state_d = ST_HOST;
			end
			default: begin
				state_d = ST_STRAP;
				cnt_d   = 32'h00000000;
			end
		endcase
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_STRAP;
			cnt_q   <= 32'h00000000;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Straps are caught on the first clock after reset release, never by the reset itself
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			demo_q   <= 1'b0;
			slave_q  <= 1'b0;
			invert_q <= 1'b0;
		end else if (state_q == ST_STRAP) begin
			demo_q   <= demo_jumper_in;
			slave_q  <= slave_jumper_in && !demo_jumper_in;
			invert_q <= slave_jumper_in && demo_jumper_in;
		end
	end

	// Sensor-facing commands; the request holds until the sensor port acknowledges
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sensor_reset_cmd_out          <= 1'b0;
			sensor_register_write_cmd_out <= 1'b0;
			sreg_addr_out                 <= 8'h00;
			sreg_data_out                 <= 8'h00;
			track_window_cmd_out          <= 1'b0;
			demo_ycc_q                    <= 1'b0;
		end else begin
			sensor_reset_cmd_out          <= (state_d == ST_CRST);
			sensor_register_write_cmd_out <= (state_d == ST_WR18) || (state_d == ST_WR19);
			sreg_addr_out                 <= (state_d == ST_WR19) ? `DSV_SREG_FMT : `DSV_SREG_GAIN;
			sreg_data_out                 <= `DSV_SREG_VAL;
			track_window_cmd_out          <= (state_d == ST_TRACK) || host_track_q;
			if (state_q == ST_WR19 && sreg_done_in)
				demo_ycc_q <= 1'b1;
		end
	end

	// Host control register; refused outright while the demo owns the port
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mass_mode_q  <= 2'h0;
			host_ycc_q   <= 1'b0;
			host_track_q <= 1'b0;
		end else begin
			host_track_q <= 1'b0;
			if (ctrl_wr) begin
				mass_mode_q  <= pwdata_in[`DSV_CTRL_MASS_MSB:`DSV_CTRL_MASS_LSB];
				host_ycc_q   <= pwdata_in[`DSV_CTRL_YCC];
				host_track_q <= pwdata_in[`DSV_CTRL_TRACK];
			end
		end
	end

	// Servo steering toward the centroid
	assign cx_right = centroid_x_in > `DSV_CENTER_X + `DSV_DEADBAND;
	assign cx_left  = centroid_x_in < `DSV_CENTER_X - `DSV_DEADBAND;

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			servo_en_q <= 1'b0;
			pos_q      <= `DSV_POS_MID;
			cx_q       <= 8'h00;
		end else begin
			if (state_q == ST_TRACK)
				servo_en_q <= 1'b1;
			else if (host_track_q && !demo_q)
				servo_en_q <= (mass_mode_q == `DSV_MASS_SERVO);
			if (centroid_valid_in) begin
				cx_q <= centroid_x_in;
				if (servo_en_q && cx_right)
					pos_q <= step_pos(pos_q, !invert_q);
				else if (servo_en_q && cx_left)
					pos_q <= step_pos(pos_q, invert_q);
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out <= 32'h00000000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= 32'h00000000;
			case (paddr_in)
				`DSV_ADDR_CTRL: begin
					prdata_out[`DSV_CTRL_MASS_MSB:`DSV_CTRL_MASS_LSB] <= mass_mode_q;
					prdata_out[`DSV_CTRL_YCC]                     <= host_ycc_q;
				end
				`DSV_ADDR_STATUS: begin
					prdata_out[8:0]           <= state_q;
					prdata_out[`DSV_ST_DEMO]  <= demo_q;
					prdata_out[`DSV_ST_SLAVE] <= slave_q;
					prdata_out[`DSV_ST_SERVO] <= servo_en_q;
					prdata_out[`DSV_ST_INV]   <= invert_q;
				end
				`DSV_ADDR_SERVO: begin
					prdata_out[7:0] <= pos_q;
				end
				`DSV_ADDR_CENTROID: begin
					prdata_out[7:0] <= cx_q;
				end
				default: begin
					prdata_out <= 32'h00000000;
				end
			endcase
		end
	end

	dsv_ycc u_ycc (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.ycc_in       (demo_ycc_q || host_ycc_q),
		.pix_valid_in (pix_valid_in),
		.red_in       (red_in),
		.green_in     (green_in),
		.blue_in      (blue_in),
		.pix_valid_out(pix_valid_out),
		.red_out      (red_out),
		.green_out    (green_out),
		.blue_out     (blue_out)
	);

	dsv_servo_pwm #(
		.FRAME_CYC(FRAME_CYC),
		.MIN_CYC  (MIN_CYC),
		.STEP_CYC (STEP_CYC)
	) u_servo (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.en_in    (servo_en_q),
		.pos_in   (pos_q),
		.servo_out(servo_out)
	);
endmodule // dsv_demo_start

//--- dsv_regs.vh
// Constants for the demo servo tracking start-up block
`ifndef DSV_REGS_VH
`define DSV_REGS_VH
`define DSV_CLK_KHZ        250000
`define DSV_SETTLE_MS      5000
`define DSV_SERVO_FRAME_MS 20
`define DSV_SERVO_MIN_MS   1
`define DSV_SERVO_MAX_MS   2
`define DSV_CAM_RST_CYC    16'h00FA
`define DSV_SREG_GAIN      8'h12
`define DSV_SREG_FMT       8'h13
`define DSV_SREG_VAL       8'h20
`define DSV_MASS_SERVO     2'h2
`define DSV_PIX_MIN        8'h10
`define DSV_PIX_MAX        8'hF0
`define DSV_CHROMA_OFS     10'h080
`define DSV_Y_COEF_G       8'h97
`define DSV_Y_COEF_R       8'h4F
`define DSV_Y_COEF_B       8'h1C
`define DSV_CENTER_X       8'h28
`define DSV_DEADBAND       8'h02
`define DSV_POS_MID        8'h80
`define DSV_ADDR_CTRL      12'h000
`define DSV_ADDR_STATUS    12'h004
`define DSV_ADDR_SERVO     12'h008
`define DSV_ADDR_CENTROID  12'h00C
`define DSV_CTRL_MASS_LSB  0
`define DSV_CTRL_MASS_MSB  1
`define DSV_CTRL_TRACK     2
`define DSV_CTRL_YCC       3
`define DSV_ST_DEMO        9
`define DSV_ST_SLAVE       10
`define DSV_ST_SERVO       11
`define DSV_ST_INV         12
`endif

//--- dsv_ycc.v
// Colour space conversion and pixel range limiting
`timescale 1ns/1ps
`include "dsv_regs.vh"
module dsv_ycc (
	input  wire       mclk_in,
	input  wire       rst_in,
	input  wire       ycc_in,
	input  wire       pix_valid_in,
	input  wire [7:0] red_in,
	input  wire [7:0] green_in,
	input  wire [7:0] blue_in,
	output reg        pix_valid_out,
	output reg  [7:0] red_out,
	output reg  [7:0] green_out,
	output reg  [7:0] blue_out
);
	wire [17:0] y_sum;
	wire [9:0]  y_val;
	wire [9:0]  cr_val;
	wire [9:0]  cb_val;

	function [7:0] clamp;
		input [9:0] v;
		begin
			if (v[9] || v < {2'b00, `DSV_PIX_MIN})
				clamp = `DSV_PIX_MIN;
			else if (v > {2'b00, `DSV_PIX_MAX})
				clamp = `DSV_PIX_MAX;
			else
				clamp = v[7:0];
		end
	endfunction

	// Coefficients are scaled by 256; their sum is slightly over one, so Y is clamped too
	assign y_sum  = green_in * `DSV_Y_COEF_G + red_in * `DSV_Y_COEF_R + blue_in * `DSV_Y_COEF_B;
	assign y_val  = y_sum[17:8];
	// Differences are offset to mid-scale so negative chroma stays representable
	assign cr_val = {2'b00, red_in} - y_val + `DSV_CHROMA_OFS;
	assign cb_val = {2'b00, blue_in} - y_val + `DSV_CHROMA_OFS;

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pix_valid_out <= 1'b0;
			red_out       <= 8'h00;
			green_out     <= 8'h00;
			blue_out      <= 8'h00;
		end else begin
			pix_valid_out <= pix_valid_in;
			if (ycc_in) begin
				red_out   <= clamp(cr_val);
				green_out <= clamp(y_val);
				blue_out  <= clamp(cb_val);
			end else begin
				red_out   <= clamp({2'b00, red_in});
				green_out <= clamp({2'b00, green_in});
				blue_out  <= clamp({2'b00, blue_in});
			end
		end
	end
endmodule // dsv_ycc

//--- dsv_servo_pwm.v
// Hobby servo pulse generator
`timescale 1ns/1ps
`include "dsv_regs.vh"
module dsv_servo_pwm #(
	parameter [31:0] FRAME_CYC = 32'd5000000,
	parameter [31:0] MIN_CYC   = 32'd250000,
	parameter [31:0] STEP_CYC  = 32'd976
) (
	input  wire       mclk_in,
	input  wire       rst_in,
	input  wire       en_in,
	input  wire [7:0] pos_in,
	output reg        servo_out
);
	reg  [31:0] cnt_q;
	reg  [31:0] width_q;

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q     <= 32'h00000000;
			width_q   <= MIN_CYC;
			servo_out <= 1'b0;
		end else begin
			if (cnt_q >= FRAME_CYC - 32'h00000001) begin
				cnt_q   <= 32'h00000000;
				// Width is latched per frame so a pulse never changes mid-flight
				width_q <= MIN_CYC + {24'h000000, pos_in} * STEP_CYC;
			end else begin
				cnt_q <= cnt_q + 32'h00000001;
			end
			servo_out <= en_in && (cnt_q < width_q);
		end
	end
endmodule // dsv_servo_pwm

//--- dsv_props.sv
// Checker for the demo start-up block ports
`timescale 1ns/1ps
module dsv_props (
	input wire        mclk_in,
	input wire        rst_in,
	input wire        demo_jumper_in,
	input wire        slave_jumper_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire        pwrite_in,
	input wire        pslverr_out,
	input wire        host_serial_en_out,
	input wire        sensor_reset_cmd_out,
	input wire        sensor_register_write_cmd_out,
	input wire [7:0]  sreg_addr_out,
	input wire [7:0]  sreg_data_out,
	input wire        sreg_done_in,
	input wire        track_window_cmd_out,
	input wire        pix_valid_out,
	input wire [7:0]  red_out,
	input wire [7:0]  green_out,
	input wire [7:0]  blue_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	AST_RST_HOLD: assert property ($rose(sensor_reset_cmd_out) |-> sensor_reset_cmd_out[*8])
		else $error("sensor reset pulse too short");
	AST_LOCK: assert property (sensor_reset_cmd_out |-> !host_serial_en_out)
		else $error("host port open during demo");
	AST_REFUSE: assert property (psel_in && penable_in && pwrite_in && !host_serial_en_out |-> pslverr_out)
		else $error("host write accepted during demo");
	AST_WR_HOLD: assert property (sensor_register_write_cmd_out && !sreg_done_in
		|=> sensor_register_write_cmd_out && $stable(sreg_addr_out))
		else $error("sensor write dropped before acknowledge");
	AST_WR_VAL: assert property (sensor_register_write_cmd_out
		|-> sreg_data_out == 8'h20 && (sreg_addr_out == 8'h12 || sreg_addr_out == 8'h13))
		else $error("wrong sensor write");
	AST_TRACK_END: assert property ($fell(sensor_register_write_cmd_out) |-> ##[0:2] track_window_cmd_out)
		else $error("no track window after sensor writes");
	AST_TRACK_PULSE: assert property (track_window_cmd_out |=> !track_window_cmd_out)
		else $error("track window pulse too long");
	AST_SLAVE: assert property (slave_jumper_in && !demo_jumper_in
		|-> !sensor_reset_cmd_out && !sensor_register_write_cmd_out)
		else $error("slave board touched the sensor");
	AST_PIX_RNG: assert property (pix_valid_out |-> red_out inside {[8'h10:8'hF0]}
		&& green_out inside {[8'h10:8'hF0]} && blue_out inside {[8'h10:8'hF0]})
		else $error("pixel out of range");
endmodule // dsv_props
bind dsv_demo_start dsv_props u_props (.mclk_in(mclk_in), .rst_in(rst_in), .demo_jumper_in(demo_jumper_in),
	.slave_jumper_in(slave_jumper_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.pslverr_out(pslverr_out), .host_serial_en_out(host_serial_en_out), .sensor_reset_cmd_out(sensor_reset_cmd_out),
	.sensor_register_write_cmd_out(sensor_register_write_cmd_out), .sreg_addr_out(sreg_addr_out),
	.sreg_data_out(sreg_data_out), .sreg_done_in(sreg_done_in), .track_window_cmd_out(track_window_cmd_out),
	.pix_valid_out(pix_valid_out), .red_out(red_out), .green_out(green_out), .blue_out(blue_out));

//--- dsv_sensor_model.sv
// Sensor port model that acknowledges register writes
`timescale 1ns/1ps
module dsv_sensor_model (
	input  wire       mclk_in,
	input  wire       cmd_in,
	input  wire [7:0] addr_in,
	input  wire [7:0] data_in,
	output reg        done_out
);
	reg [7:0] wa [0:3];
	reg [7:0] wd [0:3];
	integer   n;
	initial begin
		done_out = 1'b0;
		n = 0;
		forever begin
			@(posedge mclk_in);
			if (cmd_in === 1'b1) begin
				// Random latency so the sequencer must really wait for each acknowledge
				repeat ($urandom % 4) @(posedge mclk_in);
				// The host side has no path to the sensor write command, so only demo writes land here
				wa[n % 4] = addr_in;
				wd[n % 4] = data_in;
				n = n + 1;
				done_out <= 1'b1;
				@(posedge mclk_in);
				done_out <= 1'b0;
			end
		end
	end
endmodule // dsv_sensor_model

//--- demo_servo_tracking_startup_tb_top.sv
// Testbench for the demo start-up block
`timescale 1ns/1ps
module demo_servo_tracking_startup_tb_top;
	reg         mclk_in = 0, rst_in = 1, dj = 0, sj = 0, psel = 0, pen = 0, pwr = 0, cv = 0, pv = 0, er;
	reg  [11:0] pa = 0;
	reg  [31:0] pwd = 0, rd;
	reg  [7:0]  cx = 0, r = 0, g = 0, b = 0;
	wire [31:0] prd;
	wire [7:0]  sa, sd, ro, go, bo;
	wire        prdy, perr, srst, swr, done, trk, hen, pvo, servo;
	integer     errors = 0, samples_checked = 0, i, t;
	always #2 mclk_in = ~mclk_in;
	dsv_demo_start #(.SETTLE_CYC(200), .FRAME_CYC(2000), .MIN_CYC(100), .MAX_CYC(356)) dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .demo_jumper_in(dj), .slave_jumper_in(sj),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .sensor_reset_cmd_out(srst),
		.sensor_register_write_cmd_out(swr), .sreg_addr_out(sa), .sreg_data_out(sd), .sreg_done_in(done),
		.track_window_cmd_out(trk), .centroid_valid_in(cv), .centroid_x_in(cx), .host_serial_en_out(hen),
		.pix_valid_in(pv), .red_in(r), .green_in(g), .blue_in(b), .pix_valid_out(pvo), .red_out(ro),
		.green_out(go), .blue_out(bo), .servo_out(servo));
	dsv_sensor_model m (.mclk_in(mclk_in), .cmd_in(swr), .addr_in(sa), .data_in(sd), .done_out(done));
	task wrap_up;
		begin
			$display("errors=%0d samples_checked=%0d", errors, samples_checked);
			if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked++;
			if (got !== exp) begin
				errors++;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge mclk_in);
			psel <= 1;
			pen <= 0;
			pwr <= w;
			pa <= a;
			pwd <= d;
			@(posedge mclk_in);
			pen <= 1;
			t = 0;
			do begin
				@(posedge mclk_in);
				t++;
			end while (prdy !== 1'b1 && t < 20);
			if (t >= 20) begin
				errors++;
				wrap_up;
			end
			rd = prd;
			er = perr;
			psel <= 0;
			pen <= 0;
		end
	endtask
	// Waits for reset cmd, write cmd, track window or servo high
	task wt(input integer s);
		begin
			t = 0;
			while ((s == 0 ? srst : s == 1 ? swr : s == 2 ? trk : servo) !== 1'b1 && t < 3000) begin
				@(posedge mclk_in);
				t++;
			end
			if (t >= 3000) begin
				errors++;
				wrap_up;
			end
		end
	endtask
	task boot(input d, input s);
		begin
			@(posedge mclk_in);
			rst_in <= 1;
			dj <= d;
			sj <= s;
			repeat (12) @(posedge mclk_in);
			rst_in <= 0;
			repeat (2) @(posedge mclk_in);
		end
	endtask
	function [7:0] cl(input integer v);
		cl = v < 16 ? 16 : v > 240 ? 240 : v;
	endfunction
	task px(input ycc);
		integer k, y;
		begin
			for (k = 0; k < 8; k++) begin
				@(posedge mclk_in);
				// Full byte range on purpose so the clamp is exercised
				r <= $urandom;
				g <= $urandom;
				b <= $urandom;
				pv <= 1;
				@(posedge mclk_in);
				#1;
				chk(pvo, 1);
				y = (151 * g + 79 * r + 28 * b) >> 8;
				if (ycc) chk({ro, go, bo}, {cl(r - y + 128), cl(y), cl(b - y + 128)});
				else chk({ro, go, bo}, {cl(r), cl(g), cl(b)});
			end
			@(posedge mclk_in);
			pv <= 0;
		end
	endtask
	task cen(input [7:0] x);
		begin
			@(posedge mclk_in);
			cv <= 1;
			cx <= x;
			@(posedge mclk_in);
			cv <= 0;
			apb(0, 12'h008, 0);
		end
	endtask
	initial begin
		void'($urandom(34));
		boot(1, 0);
		wt(0);
		chk(hen, 0);
		wt(1);
		chk(t >= 450, 1);
		wt(2);
		chk({m.wa[0], m.wd[0], m.wa[1], m.wd[1]}, 32'h12201320);
		chk(m.n, 2);
		apb(0, 12'h004, 0);
		chk(rd[12:9], 4'h5);
		apb(1, 12'h000, 32'h8);
		chk(er, 1);
		wt(3);
		// Each pass measures one high pulse, then the low gap up to the next one
		for (i = 0; i < 2; i++) begin
			t = 0;
			while (servo === 1'b1 && t < 3000) begin
				@(posedge mclk_in);
				t++;
			end
			chk(t, 228);
			wt(3);
			chk(t, 1772);
		end
		px(1);
		cen(8'h32);
		chk(rd, 32'h81);
		apb(0, 12'h00C, 0);
		chk(rd, 32'h32);
		cen(8'h10);
		chk(rd, 32'h80);
		boot(1, 1);
		wt(2);
		chk({m.wa[2], m.wd[2], m.wa[3], m.wd[3]}, 32'h12201320);
		cen(8'h32);
		chk(rd, 32'h7F);
		boot(0, 1);
		apb(0, 12'h004, 0);
		chk(rd[12:0], 13'h0480);
		chk(hen, 1);
		px(0);
		for (i = 0; i < 4; i++) begin
			apb(1, 12'h000, i | 4);
			apb(0, 12'h004, 0);
			chk(rd[11], i == 2);
		end
		apb(1, 12'h000, 32'h8);
		px(1);
		apb(0, 12'h000, 0);
		chk(rd, 32'h8);
		chk(m.n, 4);
		apb(0, 12'h010, 0);
		chk({er, rd[30:0]}, 32'h80000000);
		wrap_up;
	end
endmodule // demo_servo_tracking_startup_tb_top
